/* File: src/efsa_defs.vh */
// constants for the e1 framer with frame sync and alarm aggregation
// assumes a 250 MHz sys_clk and an apb master with 32-bit data
//
// Functional notes
// - e1 line at 2.048 MHz, framed, payload ones
// - frame marker pulses once per frame, 8 kHz
// - logic clock 2.048 MHz, coherent with line
// - realign on first bit edge after sync rises
// - reference monitor output high unless condition present
// - operation alarm output high unless alarm present
// - line disabled when cesium operation indication drops
// - alarm on reference, lock or output loss
// - alarm lights lamp, lowers flag, energises relay
// - relay contacts: normal 2-3, alarm 1-3
// - synth-only fault shows lock and alarm lamps
// - detect each frame start, one marker each
`ifndef EFSA_DEFS_VH
`define EFSA_DEFS_VH

// ------------------------------------------------------------
// clocking and timing
// ------------------------------------------------------------
`define EFSA_SYS_CLK_KHZ   18'd250000
`define EFSA_SYS_CLK_MHZ   250
`define EFSA_HALF_STEP_KHZ 18'd4096
`define EFSA_LOSS_NS       1000
`define EFSA_LOSS_CYC      ((`EFSA_LOSS_NS * `EFSA_SYS_CLK_MHZ + 999) / 1000)

// ------------------------------------------------------------
// frame structure
// ------------------------------------------------------------
`define EFSA_LAST_BIT      3'h7
`define EFSA_LAST_SLOT     5'h1F
`define EFSA_LAST_FRAME    4'hF
`define EFSA_SLOT_SIG      5'h10
`define EFSA_OCT_FAS       8'h9B
`define EFSA_OCT_NFAS      8'hDF
`define EFSA_OCT_MAS       8'h0B
`define EFSA_OCT_IDLE      8'hFF
`define EFSA_CABLE_OK      4'h7

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define EFSA_ADDR_CTRL     8'h00
`define EFSA_ADDR_STATUS   8'h04
`define EFSA_ADDR_FRAMES   8'h08
`define EFSA_ADDR_SYNCS    8'h0C
`define EFSA_CTRL_LINE_EN  0
`define EFSA_CTRL_SYNC_EN  1
`define EFSA_CTRL_RESET    2'h3

`endif

/* File: src/efsa_fifo.v */
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and flush
`timescale 1ns/100ps
module efsa_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             flush,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  // ------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // word storage
  reg [AW-1:0]    wrPtr_q;         // next write slot
  reg [AW-1:0]    rdPtr_q;         // next read slot
  reg [AW:0]      count_q;         // words held

  wire push = inValid & inReady;   // accepted write
  wire pop  = outValid & outReady; // accepted read

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q];

  // write into storage
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointer and occupancy update, flush empties at once
  always @(posedge sys_clk) begin
    if (rst | flush) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

/* File: src/efsa_top.v */
// e1 framed all-ones generator with frame marker, sync and alarms
// assumes synchronous inputs, an apb master, and the cesium
// module status levels as plain inputs
`timescale 1ns/100ps
`include "efsa_defs.vh"
module efsa_top (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  input  wire        frameAlignInputN,
  input  wire        refPresent,
  input  wire        pllLocked,
  input  wire        cesiumOperating,
  input  wire        cesiumLocked,
  input  wire        cesiumMonitorCond,
  input  wire [3:0]  cableSelect,
  output reg         lineClk_q,
  output reg         linePos_q,
  output reg         lineNeg_q,
  output reg         frameStartPulseOut_q,
  output reg         refMonitorOk_q,
  output reg         operationFaultFlagN_q,
  output reg         alarmLamp_q,
  output reg         lockLamp_q,
  output reg         relayOn_q,
  output reg         contact1to3_q,
  output reg         contact2to3_q
);

  // ------------------------------------------------------------
  // octet content for a given frame and slot
  // ------------------------------------------------------------
  function [7:0] octetFor;
    input [3:0] frame;
    input [4:0] slot;
    begin
      if (slot == 5'h00) begin
        octetFor = frame[0] ? `EFSA_OCT_NFAS : `EFSA_OCT_FAS;
      end else if (slot == `EFSA_SLOT_SIG && frame == 4'h0) begin
        octetFor = `EFSA_OCT_MAS;
      end else begin
        octetFor = `EFSA_OCT_IDLE;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [17:0] acc_q;          // fractional half-bit accumulator
  reg [1:0]  ctrl_q;         // line enable, sync enable
  reg [31:0] frameCount_q;   // frames started
  reg [31:0] syncCount_q;    // realignments done
  reg        alignPrev_q;    // last sample of sync input
  reg        syncPend_q;     // realign waits for bit edge
  reg [2:0]  bitIdx_q;       // bit within slot
  reg [4:0]  slotIdx_q;      // slot within frame
  reg [3:0]  frameIdx_q;     // frame within multiframe
  reg [7:0]  shReg_q;        // remaining bits of octet
  reg        lineBit_q;      // current line bit
  reg        polarity_q;     // ami mark polarity
  reg        underrun_q;     // sticky fifo underrun
  reg [4:0]  genSlot_q;      // generator slot
  reg [3:0]  genFrame_q;     // generator frame
  reg [8:0]  lossCnt_q;      // cycles since last bit edge

  // ------------------------------------------------------------
  // tick generation
  // ------------------------------------------------------------
  wire [17:0] accSum   = acc_q + `EFSA_HALF_STEP_KHZ;
  wire        halfTick = (accSum >= `EFSA_SYS_CLK_KHZ);
  wire        bitTick  = halfTick & ~lineClk_q; // clock rises
  wire        doAlign  = bitTick & syncPend_q;
  wire        lastBit  = (bitIdx_q == `EFSA_LAST_BIT);
  wire        lastSlot = (slotIdx_q == `EFSA_LAST_SLOT);

  // fifo hookup
  wire       genValid = 1'b1;   // generator always has an octet
  wire       genReady;          // fifo has room
  wire       octValid;          // octet available
  wire [7:0] octData;           // octet at head
  wire       octPop = bitTick & ~doAlign & lastBit;
  wire [7:0] nextOct = octValid ? octData : `EFSA_OCT_IDLE;
  wire [7:0] fasOct  = `EFSA_OCT_FAS; // alignment octet loaded on realign

  // alarm causes
  wire outLost    = (lossCnt_q >= `EFSA_LOSS_CYC);
  wire synthAlarm = ~refPresent | ~pllLocked | outLost;
  wire cesAlarm   = ~cesiumOperating;
  wire lineOn     = ctrl_q[`EFSA_CTRL_LINE_EN] & cesiumOperating;

  // apb decode
  wire apbAcc   = psel & penable & pready_q;
  wire apbWr    = apbAcc & pwrite;
  wire mapped   = (paddr == `EFSA_ADDR_CTRL) | (paddr == `EFSA_ADDR_STATUS) |
                  (paddr == `EFSA_ADDR_FRAMES) | (paddr == `EFSA_ADDR_SYNCS);
  wire syncClr  = apbWr & (paddr == `EFSA_ADDR_SYNCS);
  wire [31:0] status = {19'h0, cesiumLocked, cableSelect,
                        underrun_q, (cableSelect == `EFSA_CABLE_OK),
                        lineOn, cesAlarm, synthAlarm, outLost,
                        ~pllLocked, ~refPresent};

  // ------------------------------------------------------------
  // octet buffer between generator and serializer
  // ------------------------------------------------------------
  efsa_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .flush    (doAlign),
    .inValid  (genValid),
    .inReady  (genReady),
    .inData   (octetFor(genFrame_q, genSlot_q)),
    .outValid (octValid),
    .outReady (octPop),
    .outData  (octData)
  );

  // ------------------------------------------------------------
  // line clock from fractional accumulator
  // ------------------------------------------------------------
  // half-bit ticks at 4.096 MHz with no long-term drift
  always @(posedge sys_clk) begin
    if (rst) begin
      acc_q     <= 18'h00000;
      lineClk_q <= 1'b0;
    end else begin
      acc_q <= halfTick ? accSum - `EFSA_SYS_CLK_KHZ : accSum;
      if (halfTick) begin
        lineClk_q <= ~lineClk_q;
      end
    end
  end

  // ------------------------------------------------------------
  // octet generator, stalls while the fifo is full
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      genSlot_q  <= 5'h00;
      genFrame_q <= 4'h0;
    end else if (doAlign) begin
      // serializer loads slot 0 itself, restart behind it
      genSlot_q  <= 5'h01;
      genFrame_q <= 4'h0;
    end else if (genReady) begin
      genSlot_q <= genSlot_q + 5'h01;
      if (genSlot_q == `EFSA_LAST_SLOT) begin
        genFrame_q <= genFrame_q + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // frame sync input edge capture
  // ------------------------------------------------------------
  // the far end returns the pulse high; act on the next bit edge
  always @(posedge sys_clk) begin
    if (rst) begin
      alignPrev_q <= 1'b1;
      syncPend_q  <= 1'b0;
    end else begin
      alignPrev_q <= frameAlignInputN;
      if (~alignPrev_q & frameAlignInputN & ctrl_q[`EFSA_CTRL_SYNC_EN]) begin
        syncPend_q <= 1'b1;
      end else if (bitTick) begin
        syncPend_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // serializer and frame position
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      bitIdx_q   <= `EFSA_LAST_BIT;
      slotIdx_q  <= `EFSA_LAST_SLOT;
      frameIdx_q <= `EFSA_LAST_FRAME;
      shReg_q    <= `EFSA_OCT_IDLE;
      lineBit_q  <= 1'b1;
      underrun_q <= 1'b0;
    end else if (doAlign) begin
      // new frame boundary starts with this bit
      bitIdx_q   <= 3'h0;
      slotIdx_q  <= 5'h00;
      frameIdx_q <= 4'h0;
      lineBit_q  <= fasOct[7];
      shReg_q    <= {fasOct[6:0], 1'b0};
    end else if (bitTick) begin
      bitIdx_q <= bitIdx_q + 3'h1;
      if (lastBit) begin
        slotIdx_q <= slotIdx_q + 5'h01;
        if (lastSlot) begin
          frameIdx_q <= frameIdx_q + 4'h1;
        end
        lineBit_q <= nextOct[7];
        shReg_q   <= {nextOct[6:0], 1'b0};
        if (~octValid) begin
          underrun_q <= 1'b1;
        end
      end else begin
        lineBit_q <= shReg_q[7];
        shReg_q   <= {shReg_q[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // line drive and frame marker
  // ------------------------------------------------------------
  // ami marks follow each bit edge; disable drops both rails at once
  always @(posedge sys_clk) begin
    if (rst) begin
      linePos_q            <= 1'b0;
      lineNeg_q            <= 1'b0;
      polarity_q           <= 1'b0;
      frameStartPulseOut_q <= 1'b0;
      frameCount_q         <= 32'h00000000;
    end else begin
      if (~lineOn) begin
        linePos_q <= 1'b0;
        lineNeg_q <= 1'b0;
      end else if (bitTick) begin
        // the bit taking effect is the one the serializer loads now
        linePos_q <= 1'b0;
        lineNeg_q <= 1'b0;
      end else if (halfTick == 1'b0 && lossCnt_q == 9'h001) begin
        linePos_q  <= lineBit_q & ~polarity_q;
        lineNeg_q  <= lineBit_q & polarity_q;
        polarity_q <= polarity_q ^ lineBit_q;
      end
      if (bitTick) begin
        // high for the whole first bit of slot 0
        frameStartPulseOut_q <= doAlign | (lastBit & lastSlot);
        if (doAlign | (lastBit & lastSlot)) begin
          frameCount_q <= frameCount_q + 32'h00000001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // output loss watchdog
  // ------------------------------------------------------------
  // bit edges come every 122 or 123 cycles; a long gap means lost output
  always @(posedge sys_clk) begin
    if (rst) begin
      lossCnt_q <= 9'h000;
    end else if (bitTick) begin
      lossCnt_q <= 9'h000;
    end else if (~outLost) begin
      lossCnt_q <= lossCnt_q + 9'h001;
    end
  end

  // ------------------------------------------------------------
  // alarm outputs, follow causes every cycle
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      refMonitorOk_q        <= 1'b1;
      operationFaultFlagN_q <= 1'b1;
      alarmLamp_q           <= 1'b0;
      lockLamp_q            <= 1'b0;
      relayOn_q             <= 1'b0;
      contact1to3_q         <= 1'b0;
      contact2to3_q         <= 1'b1;
    end else begin
      refMonitorOk_q        <= ~cesiumMonitorCond;
      operationFaultFlagN_q <= ~(synthAlarm | cesAlarm);
      alarmLamp_q           <= synthAlarm | cesAlarm;
      lockLamp_q            <= cesiumLocked;
      relayOn_q             <= synthAlarm;
      contact1to3_q         <= synthAlarm;
      contact2to3_q         <= ~synthAlarm;
    end
  end

  // ------------------------------------------------------------
  // apb slave, no wait states
  // ------------------------------------------------------------
  // pready rises in the first access cycle; write and read then
  always @(posedge sys_clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      ctrl_q    <= `EFSA_CTRL_RESET;
    end else begin
      pready_q  <= psel & ~pready_q & (penable | ~penable) & ~apbAcc;
      pslverr_q <= psel & ~pready_q & ~apbAcc & ~mapped;
      if (psel & ~pready_q & ~apbAcc) begin
        case (paddr)
          `EFSA_ADDR_CTRL:   prdata_q <= {30'h0, ctrl_q};
          `EFSA_ADDR_STATUS: prdata_q <= status;
          `EFSA_ADDR_FRAMES: prdata_q <= frameCount_q;
          `EFSA_ADDR_SYNCS:  prdata_q <= syncCount_q;
          default:           prdata_q <= 32'h00000000;
        endcase
      end
      if (apbWr & (paddr == `EFSA_ADDR_CTRL)) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

  // realignment counter, a count in the clearing cycle wins
  always @(posedge sys_clk) begin
    if (rst) begin
      syncCount_q <= 32'h00000000;
    end else if (doAlign) begin
      syncCount_q <= syncClr ? 32'h00000001 : syncCount_q + 32'h00000001;
    end else if (syncClr) begin
      syncCount_q <= 32'h00000000;
    end
  end

endmodule

/* File: dv/efsa_top_monitor.sv */
// concurrent checks on the ports of the e1 framer top
// assumes bind into efsa_top, sys_clk domain only, rst sync high
`timescale 1ns/100ps
module efsa_top_monitor (
  input logic sys_clk,
  input logic rst,
  input logic refPresent,
  input logic pllLocked,
  input logic cesiumOperating,
  input logic cesiumLocked,
  input logic cesiumMonitorCond,
  input logic lineClk_q,
  input logic linePos_q,
  input logic lineNeg_q,
  input logic frameStartPulseOut_q,
  input logic refMonitorOk_q,
  input logic operationFaultFlagN_q,
  input logic alarmLamp_q,
  input logic lockLamp_q,
  input logic relayOn_q,
  input logic contact1to3_q,
  input logic contact2to3_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // line clock period counter
  // ------------------------------------------------------------
  logic [7:0] gap_q;     // cycles since last line clock rise
  logic       clkPrev_q; // line clock one cycle ago
  logic       seen_q;    // a rise has been seen since reset
  wire        clkRise = lineClk_q && !clkPrev_q;
  // count cycles between rises, saturating
  always @(posedge sys_clk) begin
    if (rst) begin
      gap_q <= 8'h00;
      clkPrev_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      clkPrev_q <= lineClk_q;
      if (clkRise) begin
        gap_q <= 8'h01;
        seen_q <= 1'b1;
      end else if (gap_q != 8'hFF) begin
        gap_q <= gap_q + 8'h01;
      end
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  clk_period_a: assert property (clkRise && seen_q |-> gap_q >= 8'h79 && gap_q <= 8'h7C)
    else $error("line clock period off");
  ref_alarm_a: assert property (!refPresent |=> !operationFaultFlagN_q && alarmLamp_q)
    else $error("reference loss not flagged");
  pll_relay_a: assert property (!pllLocked |=> relayOn_q && contact1to3_q && !contact2to3_q)
    else $error("lock loss did not trip relay");
  relay_contacts_a: assert property (contact1to3_q != contact2to3_q)
    else $error("relay contacts inconsistent");
  relay_flag_a: assert property (relayOn_q |-> !operationFaultFlagN_q && alarmLamp_q)
    else $error("relay without fault flag");
  mon_out_a: assert property (1'b1 |=> refMonitorOk_q == !$past(cesiumMonitorCond))
    else $error("monitor output wrong");
  line_off_a: assert property (!cesiumOperating |=> !linePos_q && !lineNeg_q)
    else $error("line not disabled");
  ami_rails_a: assert property (!(linePos_q && lineNeg_q))
    else $error("both rails driven");
  lock_lamp_a: assert property (!$past(rst) |-> lockLamp_q == $past(cesiumLocked))
    else $error("lock lamp wrong");
  alarm_clear_a: assert property (refPresent && pllLocked && cesiumOperating && seen_q
    && gap_q < 8'h78 |=> operationFaultFlagN_q && !relayOn_q)
    else $error("alarm did not clear");
  // main scenarios reached
  cover property ($rose(frameStartPulseOut_q));
  cover property ($rose(relayOn_q));
  cover property ($fell(refMonitorOk_q));
endmodule

/* File: dv/efsa_far_end.sv */
// far-end sync source driving the active-low frame align input
// assumes the caller is just past a rising edge of sys_clk
`timescale 1ns/100ps
module efsa_far_end (
  input  logic sys_clk,
  output logic frameAlignN
);
  // idle high between pulses
  initial frameAlignN = 1'b1;
  // one brief low pulse, then back high
  task automatic pulse(input int lowCyc);
    @(posedge sys_clk);
    frameAlignN <= 1'b0;
    repeat (lowCyc) @(posedge sys_clk);
    frameAlignN <= 1'b1;
  endtask
endmodule

/* File: dv/efsa_top_tb.sv */
// self-checking bench for the e1 framer with sync and alarms
// assumes the far-end sync model and the port monitor
`timescale 1ns/100ps
module efsa_top_tb;
  logic sys_clk, rst, psel, penable, pwrite, pready_q, pslverr_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_q, rd;
  logic frameAlignInputN, refPresent, pllLocked, cesiumOperating;
  logic cesiumLocked, cesiumMonitorCond, lineClk_q, linePos_q, lineNeg_q;
  logic [3:0] cableSelect;
  logic frameStartPulseOut_q, refMonitorOk_q, operationFaultFlagN_q;
  logic alarmLamp_q, lockLamp_q, relayOn_q, contact1to3_q, contact2to3_q;
  logic err, mark, lastPos, first;
  logic [7:0] fas;
  int error_cnt, n_checks, n, w, marks, viol;
  time t0;
  // alarm inputs {ref,pll,oper,lock,mon} and outputs
  // {faultN,relay,c13,c23,lamp,monOk,lock}
  logic [4:0] almIn [5] = '{5'h0E, 5'h16, 5'h18, 5'h1F, 5'h1E};
  logic [6:0] almOut [5] = '{7'h37, 7'h37, 7'h0E, 7'h49, 7'h4B};
  efsa_top efsa_top_inst (.*);
  efsa_far_end efsa_far_end_inst (.sys_clk(sys_clk), .frameAlignN(frameAlignInputN));
  // ------------------------------------------------------------
  // clock and shared tasks
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready, keeps data and error
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge sys_clk);
      w++;
    end while (pready_q !== 1'b1 && w < 50);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 50) chk(w, 0);
  endtask
  // wait for a marker rise, at most lim cycles
  task automatic wait_mkr(input int lim);
    logic p;
    p = frameStartPulseOut_q;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (frameStartPulseOut_q && !p) break;
      p = frameStartPulseOut_q;
    end while (n < lim);
  endtask
  // verdict and end of run
  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {rst, refPresent, pllLocked, cesiumOperating, cesiumLocked} = 5'h1F;
    {psel, penable, pwrite, cesiumMonitorCond, paddr, pwdata} = '0;
    cableSelect = 4'h7;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // registers: reset value, writable bits, status, unmapped
    apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h3);
    apb(1'b1, 8'h00, 32'hFFFFFFFF); apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h3);
    apb(1'b0, 8'h04, 32'h0); chk(rd & 32'h1F7F, 32'h1760);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    // alarm table, last entry restores all-clear
    for (int i = 0; i < 5; i++) begin
      {refPresent, pllLocked, cesiumOperating, cesiumLocked, cesiumMonitorCond} <= almIn[i];
      repeat (3) @(posedge sys_clk);
      chk({operationFaultFlagN_q, relayOn_q, contact1to3_q, contact2to3_q, alarmLamp_q,
        refMonitorOk_q, lockLamp_q}, almOut[i]);
    end
    // frame: marker width, slot 0 pattern, all-ones payload, period
    wait_mkr(32000); chk(n < 32000, 1'b1);
    t0 = $time;
    {marks, viol, first, fas} = '0;
    fork
      begin
        w = 0;
        while (frameStartPulseOut_q === 1'b1) begin
          @(posedge sys_clk);
          w++;
        end
      end
      for (int b = 0; b < 128; b++) begin
        @(negedge lineClk_q);
        mark = linePos_q | lineNeg_q;
        if (b < 8) fas = {fas[6:0], mark};
        else marks += mark;
        if (mark && first && linePos_q === lastPos) viol++;
        if (mark) {first, lastPos} = {1'b1, linePos_q};
      end
    join
    chk(w >= 121 && w <= 124, 1'b1);
    chk(fas == 8'h9B || fas == 8'hDF, 1'b1);
    chk(marks, 32'd120);
    chk(viol, 32'd0);
    wait_mkr(32000); chk(($time - t0) / 4, 31250);
    // sync ignored while disabled, then realigns when enabled
    apb(1'b1, 8'h00, 32'h1);
    efsa_far_end_inst.pulse(3);
    wait_mkr(200); chk(n, 200);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h0C, 32'h0);
    efsa_far_end_inst.pulse(3);
    wait_mkr(200); chk(n >= 1 && n <= 127, 1'b1);
    // slot 0 after a realign must carry the full alignment octet
    fas = 8'h00;
    repeat (8) begin
      @(negedge lineClk_q);
      fas = {fas[6:0], linePos_q | lineNeg_q};
    end
    chk(fas, 8'h9B);
    apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h1);
    end_sim;
  end
  // watchdog well past the expected run time of just over one frame
  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end
endmodule
bind efsa_top efsa_top_monitor efsa_top_monitor_inst (.*);
